// ---- rtl/all_consts.svh ----
// Register offsets, field positions, reset values for line length config
`ifndef ALL_CONSTS_SVH
`define ALL_CONSTS_SVH
`define ALL_OFS_CHA_LO 8'h20
`define ALL_OFS_CHA_HI 8'h21
`define ALL_OFS_CHB_LO 8'h22
`define ALL_OFS_CHB_HI 8'h23
`define ALL_OFS_MODE 8'h30
`define ALL_OFS_STATUS 8'h31
`define ALL_HI_MSB 3
`define ALL_RST_BYTE 8'h00
`define ALL_RST_LEN 12'h000
`define ALL_CHMODE_TWO 2'h2
`endif

// ---- rtl/all_pkg.sv ----
// Types for the active line length configuration block
package all_pkg;
   typedef enum logic [1:0] {
      ALL_SINGLE,
      ALL_ODD_EVEN,
      ALL_LEFT_RIGHT,
      ALL_TWO_STREAM
   } all_arr_e;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } all_bus_s;
   typedef struct packed {
      logic [11:0] lenA;
      logic [11:0] lenB;
      logic useB;
      logic toOutA;
      logic toOutB;
   } all_len_s;
endpackage : all_pkg

// ---- rtl/all_len_select.sv ----
// Combines stored bytes and arrangement into the lengths each channel uses
`timescale 1ns/1ps
`include "all_consts.svh"
module all_len_select
   import all_pkg::*;
(
   // Stored fields
   input wire logic [7:0] aLo,
   input wire logic [3:0] aHi,
   input wire logic [7:0] bLo,
   input wire logic [3:0] bHi,
   // Arrangement
   input wire all_pkg::all_arr_e arr,
   input wire logic lvdsSingle,
   input wire logic [1:0] chanMode,
   // Result
   output all_pkg::all_len_s lenOut
);
   always_comb
   begin
      lenOut.lenA = {aHi, aLo}; // R2
      lenOut.lenB = 12'h000;
      lenOut.useB = 1'b0;
      lenOut.toOutA = 1'b1; // R4 R5
      lenOut.toOutB = 1'b0;
      unique case (arr)
         ALL_SINGLE:
         begin
            lenOut.lenB = 12'h000; // R7
         end
         ALL_ODD_EVEN:
         begin
            lenOut.lenB = {bHi, bLo}; // R8
            lenOut.useB = 1'b1;
            lenOut.toOutB = !lvdsSingle && (chanMode != `ALL_CHMODE_TWO); // R3
         end
         ALL_LEFT_RIGHT:
         begin
            lenOut.lenB = {bHi, bLo}; // R9
            lenOut.useB = 1'b1;
            lenOut.toOutB = 1'b1; // R9
         end
         ALL_TWO_STREAM:
         begin
            lenOut.lenB = {bHi, bLo}; // R10
            lenOut.useB = 1'b1;
            lenOut.toOutB = 1'b1; // R10
         end
      endcase
   end
endmodule : all_len_select

// ---- rtl/all_line_len_cfg.sv ----
// Active line length registers with arrangement decode and register port
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "all_consts.svh"
// Overview of operation
// R1: Each length is 12 bits; high register bits 3:0, bits 7:4 reserved.
// R2: Single input uses channel A length as active line pixels.
// R3: Odd/even: A counts odd pixels; B output only in dual LVDS, mode 00/01. The code also routes B to output B in dual LVDS, mode 11.
// R4: Left/right: A length counts left-half pixels, input A to output A.
// R5: Two-stream: A length is stream A's active pixel count.
// R6: Software programs A length after left trim when trim is nonzero.
// R7: Single input ignores channel B length fields.
// R8: Odd/even: B length counts even pixels received on input B.
// R9: Left/right: B length counts right-half pixels, input B to output B.
// R10: Two-stream: B length is stream B's active pixel count.
// R11: B low register holds bits 7:0, B high register bits 11:8.
// R12: Software programs B length after right trim when trim is nonzero.
// R13: A low register at 0x20 holds bits 7:0 of A length.
// R14: Two-stream only with dual LVDS (bit 0) and channel mode 10.
// R15: Reserved high-register bits ignore writes and read as zero.
module all_line_len_cfg
   import all_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   // Configuration defined elsewhere
   input wire logic dualInput,
   input wire logic leftRightSel,
   input wire logic lvdsSingle,
   input wire logic [1:0] chanMode,
   // Lengths in use
   output logic [11:0] lenA,
   output logic [11:0] lenB,
   output logic lenBUsed,
   output logic routeOutA,
   output logic routeOutB,
   output all_pkg::all_arr_e arrangement
);
   import all_pkg::*;

   all_bus_s bus;
   all_len_s sel;
   all_arr_e arr;
   logic [7:0] aLo_r, aLo_nxt;
   logic [3:0] aHi_r, aHi_nxt;
   logic [7:0] bLo_r, bLo_nxt;
   logic [3:0] bHi_r, bHi_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [11:0] lenA_r, lenA_nxt;
   logic [11:0] lenB_r, lenB_nxt;
   logic useB_r, useB_nxt;
   logic outA_r, outA_nxt;
   logic outB_r, outB_nxt;
   all_arr_e arr_r, arr_nxt;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

   // Crop trimming is left to software: lengths are used exactly as written
   // Arrangement decode
   always_comb
   begin
      if (!dualInput)
      begin
         arr = ALL_SINGLE;
      end
      else if (!lvdsSingle && chanMode == `ALL_CHMODE_TWO)
      begin
         arr = ALL_TWO_STREAM; // R14
      end
      else if (leftRightSel)
      begin
         arr = ALL_LEFT_RIGHT;
      end
      else
      begin
         arr = ALL_ODD_EVEN;
      end
   end

   // Register writes
   always_comb
   begin
      aLo_nxt = aLo_r;
      aHi_nxt = aHi_r;
      bLo_nxt = bLo_r;
      bHi_nxt = bHi_r;
      if (bus.wr)
      begin
         if (hit(bus.addr, `ALL_OFS_CHA_LO))
         begin
            aLo_nxt = bus.wdata; // R13
         end
         if (hit(bus.addr, `ALL_OFS_CHA_HI))
         begin
            aHi_nxt = bus.wdata[`ALL_HI_MSB:0]; // R1
         end
         if (hit(bus.addr, `ALL_OFS_CHB_LO))
         begin
            bLo_nxt = bus.wdata; // R11
         end
         if (hit(bus.addr, `ALL_OFS_CHB_HI))
         begin
            bHi_nxt = bus.wdata[`ALL_HI_MSB:0]; // R11
         end
      end
   end

   // Read data, valid in the cycle after the strobe only
   always_comb
   begin
      rdata_nxt = `ALL_RST_BYTE;
      if (bus.rd)
      begin
         if (hit(bus.addr, `ALL_OFS_CHA_LO))
         begin
            rdata_nxt = aLo_r;
         end
         else if (hit(bus.addr, `ALL_OFS_CHA_HI))
         begin
            rdata_nxt = {4'h0, aHi_r}; // R15
         end
         else if (hit(bus.addr, `ALL_OFS_CHB_LO))
         begin
            rdata_nxt = bLo_r;
         end
         else if (hit(bus.addr, `ALL_OFS_CHB_HI))
         begin
            rdata_nxt = {4'h0, bHi_r}; // R15
         end
         else if (hit(bus.addr, `ALL_OFS_MODE))
         begin
            rdata_nxt = {6'h00, arr_r};
         end
         else if (hit(bus.addr, `ALL_OFS_STATUS))
         begin
            rdata_nxt = {5'h00, useB_r, outB_r, outA_r};
         end
      end
   end

   all_len_select u_sel (
      .aLo(aLo_r),
      .aHi(aHi_r),
      .bLo(bLo_r),
      .bHi(bHi_r),
      .arr(arr),
      .lvdsSingle(lvdsSingle),
      .chanMode(chanMode),
      .lenOut(sel)
   );

   always_comb
   begin
      lenA_nxt = sel.lenA; // R2
      lenB_nxt = sel.lenB; // R7
      useB_nxt = sel.useB;
      outA_nxt = sel.toOutA;
      outB_nxt = sel.toOutB; // R3
      arr_nxt = arr;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         aLo_r <= `ALL_RST_BYTE;
         aHi_r <= 4'h0;
         bLo_r <= `ALL_RST_BYTE;
         bHi_r <= 4'h0;
         rdata_r <= `ALL_RST_BYTE;
         lenA_r <= `ALL_RST_LEN;
         lenB_r <= `ALL_RST_LEN;
         useB_r <= 1'b0;
         outA_r <= 1'b1;
         outB_r <= 1'b0;
         arr_r <= ALL_SINGLE;
      end
      else
      begin
         aLo_r <= aLo_nxt;
         aHi_r <= aHi_nxt;
         bLo_r <= bLo_nxt;
         bHi_r <= bHi_nxt;
         rdata_r <= rdata_nxt;
         lenA_r <= lenA_nxt;
         lenB_r <= lenB_nxt;
         useB_r <= useB_nxt;
         outA_r <= outA_nxt;
         outB_r <= outB_nxt;
         arr_r <= arr_nxt;
      end
   end

   assign regRdata = rdata_r;
   assign lenA = lenA_r;
   assign lenB = lenB_r;
   assign lenBUsed = useB_r;
   assign routeOutA = outA_r;
   assign routeOutB = outB_r;
   assign arrangement = arr_r;

   // Checks
   sequence s_write_ahi;
      regWr && regAddr == `ALL_OFS_CHA_HI;
   endsequence

   sequence s_write_bhi;
      regWr && regAddr == `ALL_OFS_CHB_HI;
   endsequence

   sequence s_read_bhi;
      regRd && !regWr && regAddr == `ALL_OFS_CHB_HI;
   endsequence

   sequence s_two_cfg;
      dualInput && !lvdsSingle && chanMode == `ALL_CHMODE_TWO;
   endsequence

   chk_hi_reserved_zero: assert property (@(posedge ref_clk) // R15
      disable iff (reset)
      regRd && (regAddr == `ALL_OFS_CHA_HI || regAddr == `ALL_OFS_CHB_HI)
      |=> regRdata[7:4] == 4'h0)
      else $error("reserved bits not zero");

   chk_ahi_store: assert property (@(posedge ref_clk) // R1
      disable iff (reset)
      s_write_ahi ##1 regRd && regAddr == `ALL_OFS_CHA_HI && !regWr
      |=> regRdata == ($past(regWdata, 2) & 8'h0f))
      else $error("A high nibble not stored");

   chk_alo_store: assert property (@(posedge ref_clk) // R13
      disable iff (reset)
      regWr && regAddr == `ALL_OFS_CHA_LO ##1 regRd && !regWr
      && regAddr == `ALL_OFS_CHA_LO |=> regRdata == $past(regWdata, 2))
      else $error("A low byte not stored");

   chk_blo_store: assert property (@(posedge ref_clk) // R11
      disable iff (reset)
      regWr && regAddr == `ALL_OFS_CHB_LO ##1 regRd && !regWr
      && regAddr == `ALL_OFS_CHB_LO |=> regRdata == $past(regWdata, 2))
      else $error("B low byte not stored");

   chk_len_a_follow: assert property (@(posedge ref_clk) // R2
      disable iff (reset)
      1'b1 |=> lenA == $past({aHi_r, aLo_r}))
      else $error("A length wrong");

   chk_single_ignore_b: assert property (@(posedge ref_clk) // R7
      disable iff (reset)
      !dualInput |=> lenB == 12'h000 && !lenBUsed)
      else $error("B used in single input");

   chk_two_stream: assert property (@(posedge ref_clk) // R14
      disable iff (reset)
      dualInput && !lvdsSingle && chanMode == `ALL_CHMODE_TWO
      |=> arrangement == ALL_TWO_STREAM && lenB == $past({bHi_r, bLo_r}))
      else $error("two-stream decode wrong");

   chk_odd_even_route: assert property (@(posedge ref_clk) // R3
      disable iff (reset)
      dualInput && !leftRightSel && (lvdsSingle || chanMode != `ALL_CHMODE_TWO)
      |=> routeOutA && routeOutB == !$past(lvdsSingle))
      else $error("odd/even routing wrong");

   chk_left_right: assert property (@(posedge ref_clk) // R9
      disable iff (reset)
      dualInput && leftRightSel && (lvdsSingle || chanMode != `ALL_CHMODE_TWO)
      |=> routeOutB && lenBUsed && arrangement == ALL_LEFT_RIGHT)
      else $error("left/right decode wrong");

   chk_bhi_store: assert property (@(posedge ref_clk) // R11
      disable iff (reset)
      s_write_bhi ##1 s_read_bhi
      |=> regRdata == ($past(regWdata, 2) & 8'h0f))
      else $error("B high nibble not stored");

   chk_single_arr: assert property (@(posedge ref_clk) // R2
      disable iff (reset)
      !dualInput |=> arrangement == ALL_SINGLE && routeOutA && !routeOutB)
      else $error("single input decode wrong");

   chk_odd_even_len: assert property (@(posedge ref_clk) // R8
      disable iff (reset)
      dualInput && !leftRightSel && (lvdsSingle || chanMode != `ALL_CHMODE_TWO)
      |=> arrangement == ALL_ODD_EVEN && lenBUsed
      && lenB == $past({bHi_r, bLo_r}))
      else $error("odd/even B length wrong");

   chk_lr_len: assert property (@(posedge ref_clk) // R4
      disable iff (reset)
      dualInput && leftRightSel && (lvdsSingle || chanMode != `ALL_CHMODE_TWO)
      |=> routeOutA && lenB == $past({bHi_r, bLo_r}))
      else $error("left/right lengths wrong");

   chk_two_route: assert property (@(posedge ref_clk) // R10
      disable iff (reset)
      s_two_cfg |=> lenBUsed && routeOutA && routeOutB)
      else $error("two-stream routing wrong");

   chk_mode_read: assert property (@(posedge ref_clk) // R14
      disable iff (reset)
      regRd && regAddr == `ALL_OFS_MODE
      |=> regRdata == {6'h00, $past(arrangement)})
      else $error("arrangement readback wrong");

   chk_unmapped_zero: assert property (@(posedge ref_clk) // R15
      disable iff (reset)
      regRd && (regAddr < `ALL_OFS_CHA_LO || regAddr > `ALL_OFS_STATUS)
      |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : all_line_len_cfg

// ---- verif/tb.sv ----
// Self-checking bench for the active line length configuration block
`timescale 1ns/1ps
`include "all_consts.svh"
module tb;
   import all_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdata;
   logic dualInput = 1'b0;
   logic leftRightSel = 1'b0;
   logic lvdsSingle = 1'b0;
   logic [1:0] chanMode = 2'h0;
   logic [11:0] lenA;
   logic [11:0] lenB;
   logic lenBUsed;
   logic routeOutA;
   logic routeOutB;
   all_arr_e arrangement;
   int fails = 0;
   int checks = 0;
   int seed = 94033;
   always #20 ref_clk = ~ref_clk;
   all_line_len_cfg u_all_line_len_cfg (
      .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .dualInput(dualInput),
      .leftRightSel(leftRightSel), .lvdsSingle(lvdsSingle),
      .chanMode(chanMode), .lenA(lenA), .lenB(lenB), .lenBUsed(lenBUsed),
      .routeOutA(routeOutA), .routeOutB(routeOutB),
      .arrangement(arrangement)
   );
   task automatic give_verdict();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict
   task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask : regWrite
   task automatic regRead(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRd <= 1'b0;
      @(negedge ref_clk);
      d = regRdata;
   endtask : regRead
   // Write then read the same address with no idle cycle between
   task automatic regWriteRead(input logic [7:0] a, input logic [7:0] dw,
      output logic [7:0] dr);
      @(posedge ref_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= dw;
      @(posedge ref_clk);
      regWr <= 1'b0;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      @(negedge ref_clk);
      dr = regRdata;
   endtask : regWriteRead
   // Expected {arrangement, B used, route A, route B} for a configuration
   function automatic logic [4:0] expRoute(input logic [4:0] c);
      if (!c[4])
         return {ALL_SINGLE, 3'b010};
      if (!c[2] && c[1:0] == `ALL_CHMODE_TWO)
         return {ALL_TWO_STREAM, 3'b111};
      if (c[3])
         return {ALL_LEFT_RIGHT, 3'b111};
      return {ALL_ODD_EVEN, 2'b11, ~c[2]};
   endfunction : expRoute
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      give_verdict();
   end
   initial
   begin
      logic [7:0] d;
      logic [4:0] cfg;
      logic [4:0] e;
      logic [11:0] la;
      logic [11:0] lb;
      logic [7:0] r;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      @(negedge ref_clk);
      cmp(lenA, `ALL_RST_LEN);
      cmp({7'h0, arrangement, lenBUsed, routeOutA, routeOutB}, 12'h002);
      for (int i = 0; i < 4; i++)
      begin
         regRead(`ALL_OFS_CHA_LO + i[7:0], d);
         cmp({4'h0, d}, {4'h0, `ALL_RST_BYTE});
      end
      regWrite(`ALL_OFS_MODE, 8'hff);
      regRead(`ALL_OFS_MODE, d);
      cmp({4'h0, d}, 12'h000);
      regRead(8'h40, d);
      cmp({4'h0, d}, 12'h000);
      for (int i = 0; i < 48; i++)
      begin
         cfg = (i < 32) ? i[4:0] : 5'($random(seed));
         la = 12'($random(seed));
         lb = (i == 0) ? 12'hfff : 12'($random(seed));
         r = 8'($random(seed));
         regWriteRead(`ALL_OFS_CHA_LO, la[7:0], d);
         cmp({4'h0, d}, {4'h0, la[7:0]});
         regWriteRead(`ALL_OFS_CHA_HI, {r[3:0], la[11:8]}, d);
         cmp({4'h0, d}, {8'h00, la[11:8]});
         regWriteRead(`ALL_OFS_CHB_LO, lb[7:0], d);
         cmp({4'h0, d}, {4'h0, lb[7:0]});
         regWriteRead(`ALL_OFS_CHB_HI, {r[7:4], lb[11:8]}, d);
         cmp({4'h0, d}, {8'h00, lb[11:8]});
         @(posedge ref_clk);
         dualInput <= cfg[4];
         leftRightSel <= cfg[3];
         lvdsSingle <= cfg[2];
         chanMode <= cfg[1:0];
         repeat (3) @(posedge ref_clk);
         @(negedge ref_clk);
         e = expRoute(cfg);
         cmp(lenA, la);
         cmp(lenB, e[2] ? lb : 12'h000);
         cmp({7'h0, arrangement, lenBUsed, routeOutA, routeOutB},
             {7'h0, e});
         regRead(`ALL_OFS_CHA_HI, d);
         cmp({4'h0, d}, {8'h00, la[11:8]});
         regRead(`ALL_OFS_CHB_HI, d);
         cmp({4'h0, d}, {8'h00, lb[11:8]});
         regRead(`ALL_OFS_CHB_LO, d);
         cmp({4'h0, d}, {4'h0, lb[7:0]});
         regRead(`ALL_OFS_MODE, d);
         cmp({4'h0, d}, {10'h0, e[4:3]});
         regRead(`ALL_OFS_STATUS, d);
         cmp({4'h0, d}, {9'h0, e[2], e[0], e[1]});
      end
      // Mid-run reset must clear every stored byte and derived length
      @(posedge ref_clk);
      dualInput <= 1'b0;
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      @(negedge ref_clk);
      cmp(lenA, `ALL_RST_LEN);
      cmp(lenB, `ALL_RST_LEN);
      for (int i = 0; i < 4; i++)
      begin
         regRead(`ALL_OFS_CHA_LO + i[7:0], d);
         cmp({4'h0, d}, {4'h0, `ALL_RST_BYTE});
      end
      give_verdict();
   end
endmodule : tb
